// ===== logic/wbs_pkg.sv
// Constants, field layouts and helper functions for the write buffer slice.
// Assumes one 125 MHz fabric clock that samples all processor and memory pins.
package wbs_pkg;

  localparam int          WBS_DEPTH    = 4;
  localparam logic [2:0]  WBS_CNT_FULL = 3'h4;
  localparam logic [2:0]  WBS_CNT_LAST = 3'h3;
  localparam logic [2:0]  WBS_CNT_TWO  = 3'h2;
  localparam logic [2:0]  WBS_CNT_ONE  = 3'h1;
  localparam logic [2:0]  WBS_CNT_NONE = 3'h0;
  localparam logic [1:0]  WBS_PTR_STEP = 2'h1;
  localparam logic [1:0]  WBS_LANE_LOW = 2'h0;
  localparam int          WBS_LOW_HI   = 1;
  localparam int          WBS_HIGH_LO  = 4;
  localparam logic [1:0]  WBS_SIZE_BYTE = 2'h0;
  localparam logic [1:0]  WBS_SIZE_HALF = 2'h1;
  localparam logic [1:0]  WBS_SIZE_TRI  = 2'h2;
  localparam logic [1:0]  WBS_SIZE_WORD = 2'h3;
  localparam logic [3:0]  WBS_MASK_ALL  = 4'hF;

  typedef struct packed {
    logic       clk;
    logic       strobe;
    logic [1:0] ptr;
    logic [7:0] addr;
    logic [1:0] size;
    logic [8:0] data;
    logic [1:0] lane;
    logic       big;
    logic       oe;
    logic       ack;
  } wbs_pin_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [8:0] data;
    logic [3:0] mask;
  } wbs_entry_type;

  // Bytes of the word touched by a store, indexed by address byte offset
  function automatic logic [3:0] wbs_store_mask(input logic [1:0] size, input logic [1:0] ptr);
    logic [7:0] run;
    run = {4'h0, WBS_MASK_ALL >> (WBS_SIZE_WORD - size)} << ptr;
    return run[3:0];
  endfunction

  // Offset of the first valid byte
  function automatic logic [1:0] wbs_first_byte(input logic [3:0] mask);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = WBS_DEPTH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // Size code regenerated from the number of valid bytes
  function automatic logic [1:0] wbs_mask_size(input logic [3:0] mask);
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < WBS_DEPTH; i++) begin
      cnt = cnt + {2'h0, mask[i]};
    end
    return (cnt == WBS_CNT_NONE) ? WBS_SIZE_BYTE : 2'(cnt - WBS_CNT_ONE);
  endfunction

endpackage

// ===== logic/wbs_slice.sv
// Byte-wide slice of a four-entry posted-write buffer with byte gathering.
// Assumes all pins are asynchronous to clk_i and the processor clock is
// much slower than clk_i, so both of its edges are seen as sampled events.
`timescale 1ns/1ps
module wbs_slice
  import wbs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Processor store port
  input  wire logic       proc_clock_i,
  input  wire logic       store_strobe_i,
  input  wire logic [1:0] store_ptr_i,
  input  wire logic [7:0] store_addr_slice_in_i,
  input  wire logic [1:0] store_size_in_i,
  input  wire logic [8:0] store_byte_parity_in_i,
  output logic            buffer_full_flag_o,
  // Configuration straps
  input  wire logic [1:0] slice_lane_select_i,
  input  wire logic       byte_order_select_i,
  // Memory drain port
  input  wire logic       drain_drive_enable_i,
  input  wire logic       drain_ack_i,
  output logic            drain_request_o,
  output logic [7:0]      drain_addr_slice_o,
  output logic [8:0]      drain_word_bus_o,
  output logic [1:0]      drain_size_out_o,
  output logic            drain_oe_o
);

  wbs_pin_type   pin_raw;
  wbs_pin_type   sync1;
  wbs_pin_type   sync2;
  wbs_pin_type   sync3;
  wbs_entry_type entry [WBS_DEPTH];
  logic [2:0]    count;
  logic [2:0]    next_count;
  logic [1:0]    rd_ptr;
  logic [1:0]    wr_ptr;
  logic [1:0]    tail;
  logic          cap_pending;
  logic [1:0]    cap_ptr;
  logic [3:0]    cap_low;
  logic          rise_evt;
  logic          fall_evt;
  logic          ack_evt;
  logic          commit;
  logic          merge_ok;
  logic          append;
  logic          retire;
  logic [7:0]    new_addr;
  logic [3:0]    new_mask;
  logic [1:0]    my_byte;
  logic          mine;
  logic          lane_low;
  wbs_entry_type head;

  // Two-flop synchronisers on every pin except rst_i
  assign pin_raw = '{clk: proc_clock_i, strobe: store_strobe_i, ptr: store_ptr_i,
                     addr: store_addr_slice_in_i, size: store_size_in_i,
                     data: store_byte_parity_in_i, lane: slice_lane_select_i,
                     big: byte_order_select_i, oe: drain_drive_enable_i, ack: drain_ack_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '{clk: 1'b1, default: '0};
      sync2 <= '{clk: 1'b1, default: '0};
      sync3 <= '{clk: 1'b1, default: '0};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise_evt = sync2.clk && !sync3.clk;
  assign fall_evt = !sync2.clk && sync3.clk;
  assign ack_evt  = sync2.ack && !sync3.ack;

  // Address phase on the trailing edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_pending <= 1'b0;
      cap_ptr     <= '0;
      cap_low     <= '0;
    end else if (fall_evt && sync2.strobe) begin
      cap_pending <= 1'b1;
      cap_ptr     <= sync2.ptr;
      cap_low     <= sync2.addr[WBS_HIGH_LO-1:0];
    end else if (rise_evt) begin
      cap_pending <= 1'b0;
    end
  end

  // Data phase on the leading edge completes the store
  assign commit   = rise_evt && cap_pending;
  assign lane_low = (sync2.lane == WBS_LANE_LOW);
  assign new_addr = {sync2.addr[7:WBS_HIGH_LO], cap_low[WBS_HIGH_LO-1:WBS_LOW_HI+1],
                     lane_low ? 2'h0 : cap_low[WBS_LOW_HI:0]};
  assign new_mask = wbs_store_mask(sync2.size, cap_ptr);
  assign my_byte  = sync2.big ? ~sync2.lane : sync2.lane;
  assign mine     = new_mask[my_byte];

  // The head is presented, so only a distinct tail that took the last store may gather
  assign tail     = wr_ptr - WBS_PTR_STEP;
  assign merge_ok = commit && (count >= WBS_CNT_TWO)
                    && (entry[tail].addr == new_addr);
  assign retire   = ack_evt && sync2.oe && (count != WBS_CNT_NONE);
  assign append   = commit && !merge_ok && ((count != WBS_CNT_FULL) || retire);

  always_comb begin
    next_count = count;
    if (append && !retire) begin
      next_count = count + WBS_CNT_ONE;
    end else if (retire && !append) begin
      next_count = count - WBS_CNT_ONE;
    end
  end

  // Entry storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WBS_DEPTH; i++) begin
        entry[i] <= '0;
      end
    end else if (merge_ok) begin
      entry[tail].mask <= entry[tail].mask | new_mask;
      if (mine) begin
        entry[tail].data <= sync2.data;
      end
    end else if (append) begin
      entry[wr_ptr] <= '{addr: new_addr, data: mine ? sync2.data : 9'h000,
                         mask: new_mask};
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= WBS_CNT_NONE;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else begin
      count <= next_count;
      if (append) begin
        wr_ptr <= wr_ptr + WBS_PTR_STEP;
      end
      if (retire) begin
        rd_ptr <= rd_ptr + WBS_PTR_STEP;
      end
    end
  end

  assign buffer_full_flag_o = (count == WBS_CNT_FULL)
                              || ((count == WBS_CNT_LAST) && cap_pending);

  // Request sets on a processor rising edge, drops as soon as empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_request_o <= 1'b0;
    end else if (next_count == WBS_CNT_NONE) begin
      drain_request_o <= 1'b0;
    end else if (rise_evt) begin
      drain_request_o <= 1'b1;
    end
  end

  // Oldest entry onto the drain outputs while enabled
  assign head = entry[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_oe_o         <= 1'b0;
      drain_addr_slice_o <= '0;
      drain_word_bus_o   <= '0;
      drain_size_out_o   <= '0;
    end else begin
      drain_oe_o         <= sync2.oe;
      drain_addr_slice_o <= lane_low ? {head.addr[7:WBS_LOW_HI+1], wbs_first_byte(head.mask)}
                                     : head.addr;
      drain_word_bus_o   <= head.data;
      drain_size_out_o   <= wbs_mask_size(head.mask);
    end
  end

  // Checks
  full_when_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (count == WBS_CNT_FULL) |-> buffer_full_flag_o)
    else $error("full flag low with every entry used");

  full_last_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((count == WBS_CNT_LAST) && cap_pending) |-> buffer_full_flag_o)
    else $error("full flag low while last entry is being filled");

  req_empty_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (count == WBS_CNT_NONE) |-> !drain_request_o)
    else $error("request high with empty buffer");

  req_rise_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(drain_request_o) |-> $past(rise_evt) && (count != WBS_CNT_NONE))
    else $error("request rose away from a processor clock edge");

  out_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sync2.oe ##1 !sync2.oe) |-> !drain_oe_o)
    else $error("drain outputs enabled without drive enable");

  retire_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_evt && sync2.oe && (count != WBS_CNT_NONE) && !commit) |=> (count == $past(count) - WBS_CNT_ONE))
    else $error("acknowledge did not retire the presented entry");

  last_retire_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_evt && sync2.oe && (count == WBS_CNT_ONE) && !commit) |=> !drain_request_o [*2])
    else $error("request stayed high after last entry retired");

  head_no_gather_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && (count == WBS_CNT_ONE) && !ack_evt) |=> (count == WBS_CNT_TWO))
    else $error("store gathered into the presented entry");

  gather_keeps_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (merge_ok && !retire) |=> (count == $past(count)) && (entry[$past(tail)].mask != 4'h0))
    else $error("gathered store took a new entry");

  reset_clean_a: assert property (@(posedge clk_i)
    rst_i |=> (count == WBS_CNT_NONE) && !drain_request_o && !buffer_full_flag_o)
    else $error("buffer not empty after reset");

  addr_phase_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall_evt && sync2.strobe) |=> cap_pending && (cap_ptr == $past(sync2.ptr)))
    else $error("byte pointer not taken on processor clock fall");

  low_nibble_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall_evt && sync2.strobe) |=> (cap_low == $past(sync2.addr[WBS_HIGH_LO-1:0])))
    else $error("low address nibble not taken on processor clock fall");

  no_strobe_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall_evt && !sync2.strobe && !cap_pending) |=> !cap_pending)
    else $error("address phase started without store strobe");

  data_phase_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_evt |=> !cap_pending)
    else $error("address phase left open after processor clock rise");

  append_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    append |=> (entry[$past(wr_ptr)].addr == $past(new_addr)))
    else $error("new entry holds wrong address byte");

  append_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (append && mine) |=> (entry[$past(wr_ptr)].data == $past(sync2.data)))
    else $error("own byte not stored in new entry");

  foreign_byte_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (append && !mine) |=> (entry[$past(wr_ptr)].data == 9'h000))
    else $error("byte of another slice stored in new entry");

  append_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    append |=> (entry[$past(wr_ptr)].mask == $past(new_mask)))
    else $error("new entry holds wrong byte mask");

  lane_low_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (append && lane_low) |=> (entry[$past(wr_ptr)].addr[WBS_LOW_HI:0] == 2'h0))
    else $error("lane zero slice stored low address bits");

  lane_low_regen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lane_low && head.mask[0]) |=> (drain_addr_slice_o[WBS_LOW_HI:0] == 2'h0))
    else $error("lane zero slice regenerated wrong low address bits");

  count_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count <= WBS_CNT_FULL)
    else $error("occupancy beyond four entries");

  full_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (count < WBS_CNT_LAST) |-> !buffer_full_flag_o)
    else $error("full flag high with two free entries");

  full_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (commit && !merge_ok && (count == WBS_CNT_FULL) && !retire) |=> (count == WBS_CNT_FULL))
    else $error("store into full buffer changed occupancy");

  req_pending_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (count != WBS_CNT_NONE) |-> drain_request_o)
    else $error("request low with pending entries");

  out_enable_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync2.oe |=> drain_oe_o)
    else $error("drain outputs not enabled with drive enable");

  out_data_head_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (drain_word_bus_o == $past(head.data)))
    else $error("drain data not the oldest entry");

  retire_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
    retire |=> (rd_ptr == $past(rd_ptr) + WBS_PTR_STEP))
    else $error("acknowledge did not advance to next entry");

  ack_no_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_evt && !sync2.oe) |=> (rd_ptr == $past(rd_ptr)))
    else $error("acknowledge without drive enable retired an entry");

  ack_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_evt && (count == WBS_CNT_NONE)) |=> (rd_ptr == $past(rd_ptr)))
    else $error("acknowledge on empty buffer moved read pointer");

  write_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    append |=> (wr_ptr == $past(wr_ptr) + WBS_PTR_STEP))
    else $error("new entry not placed after the previous one");

  gather_not_head_a: assert property (@(posedge clk_i) disable iff (rst_i)
    merge_ok |-> (tail != rd_ptr))
    else $error("gathering into the presented entry");

  gather_overwrite_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (merge_ok && mine) |=> (entry[$past(tail)].data == $past(sync2.data)))
    else $error("gathered own byte did not replace earlier value");

  gather_keep_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (merge_ok && !mine) |=> (entry[$past(tail)].data == $past(entry[tail].data)))
    else $error("gathered foreign store changed stored byte");

  size_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (head.mask == WBS_MASK_ALL) |=> (drain_size_out_o == WBS_SIZE_WORD))
    else $error("full word entry not shown as word size");

  size_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (head.mask == 4'h1) |=> (drain_size_out_o == WBS_SIZE_BYTE))
    else $error("single byte entry not shown as byte size");

endmodule

// ===== test/wbs_partner.sv
// Partner model: processor store port and memory controller.
// Assumes all pins change just after a falling edge of clk_i.
`timescale 1ns/1ps
module wbs_partner
  import wbs_pkg::*;
(
  // Clock and slice status
  input  wire logic   clk_i,
  input  wire logic   full_i,
  input  wire logic   oe_i,
  // Pins toward the slice
  output wbs_pin_type pin_o
);
  initial pin_o = '{clk: 1'b1, default: '0};
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic cfg(input logic [1:0] lane, input logic big);
    tick(1);
    {pin_o.lane, pin_o.big} = {lane, big};
  endtask
  // Fall carries low nibble and pointer, rise the rest; bits not due are shown wrong, except address bits 1:0 at the rise
  task automatic store(input logic [1:0] sz, pt, input logic [7:0] ad, input logic [8:0] dt, output logic ok);
    for (int n = 0; n < 400 && full_i !== 1'b0; n++) begin
      tick(1);
    end
    ok = (full_i === 1'b0);
    tick(1);
    {pin_o.clk, pin_o.strobe, pin_o.ptr, pin_o.addr, pin_o.size, pin_o.data} =
      {2'b01, pt, ~ad[7:4], ad[3:0], ~sz, ~dt};
    tick(8);
    {pin_o.clk, pin_o.ptr, pin_o.addr, pin_o.size, pin_o.data} = {1'b1, ~pt, ad[7:4], ad[3:0] ^ 4'hC, sz, dt};
    tick(8);
    {pin_o.strobe, pin_o.data} = {1'b0, ~dt};
  endtask
  task automatic wait_oe(input logic lvl, output logic ok);
    for (int n = 0; n < 20 && oe_i !== lvl; n++) begin
      tick(1);
    end
    ok = (oe_i === lvl);
  endtask
  // Enable outputs when ready, acknowledge once done with them
  task automatic open_drain(output logic ok);
    tick(1);
    pin_o.oe = 1'b1;
    wait_oe(1'b1, ok);
  endtask
  task automatic retire(output logic ok);
    pin_o.ack = 1'b1;
    tick(4);
    {pin_o.ack, pin_o.oe} = 2'b00;
    wait_oe(1'b0, ok);
  endtask
endmodule

// ===== test/wbs_slice_tb.sv
// Self-checking bench for the write buffer slice.
// Assumes the partner model drives every slice pin except clk_i and rst_i, which the bench drives.
`timescale 1ns/1ps
module wbs_slice_tb;
  import wbs_pkg::*;
  typedef struct packed {
    logic [1:0] lane, size, ptr, e_size;
    logic       big;
    logic [7:0] addr, e_addr;
    logic [8:0] data, e_data;
  } wbs_row_type;
  logic        clk, rst, full, req, d_oe;
  logic [7:0]  d_addr;
  logic [8:0]  d_data;
  logic [1:0]  d_size;
  int          fails, num_checks;
  wbs_pin_type pin;
  wbs_row_type rows [6] = '{
    '{2'h1, 2'h3, 2'h0, 2'h3, 1'b0, 8'hA5, 8'hA5, 9'h1C3, 9'h1C3},
    '{2'h0, 2'h0, 2'h2, 2'h0, 1'b0, 8'h5C, 8'h5E, 9'h0A5, 9'h000},
    '{2'h0, 2'h1, 2'h0, 2'h1, 1'b0, 8'h30, 8'h30, 9'h155, 9'h155},
    '{2'h0, 2'h2, 2'h1, 2'h2, 1'b1, 8'hF0, 8'hF1, 9'h0FF, 9'h0FF},
    '{2'h2, 2'h1, 2'h2, 2'h1, 1'b1, 8'h81, 8'h81, 9'h12A, 9'h000},
    '{2'h3, 2'h1, 2'h3, 2'h0, 1'b0, 8'h42, 8'h42, 9'h0F0, 9'h0F0}};
  wbs_slice u_wbs_slice (
    .clk_i(clk), .rst_i(rst), .proc_clock_i(pin.clk), .store_strobe_i(pin.strobe), .store_ptr_i(pin.ptr),
    .store_addr_slice_in_i(pin.addr), .store_size_in_i(pin.size), .store_byte_parity_in_i(pin.data),
    .buffer_full_flag_o(full), .slice_lane_select_i(pin.lane), .byte_order_select_i(pin.big),
    .drain_drive_enable_i(pin.oe), .drain_ack_i(pin.ack), .drain_request_o(req), .drain_addr_slice_o(d_addr),
    .drain_word_bus_o(d_data), .drain_size_out_o(d_size), .drain_oe_o(d_oe));
  wbs_partner u_wbs_partner (.clk_i(clk), .full_i(full), .oe_i(d_oe), .pin_o(pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic put(input logic [1:0] sz, pt, input logic [7:0] ad, input logic [8:0] dt);
    logic ok;
    u_wbs_partner.store(sz, pt, ad, dt, ok);
    check({8'h00, ok}, 9'h001, "stall wait");
    if (ok !== 1'b1) stop_test();
  endtask
  // Present the head entry, compare it, then acknowledge it
  task automatic pull(input logic [7:0] ea, input logic [8:0] ed, input logic [1:0] es);
    logic o1, o2;
    u_wbs_partner.open_drain(o1);
    check({1'b0, d_addr}, {1'b0, ea}, "addr");
    check(d_data, ed, "data");
    check({7'h00, d_size}, {7'h00, es}, "size");
    u_wbs_partner.retire(o2);
    check({7'h00, o1, o2}, 9'h003, "oe");
    if ({o1, o2} !== 2'b11) stop_test();
  endtask
  initial begin
    rst = 1'b1;
    fails = 0;
    num_checks = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check({6'h00, req, full, d_oe}, 9'h000, "reset");
    foreach (rows[i]) begin
      u_wbs_partner.cfg(rows[i].lane, rows[i].big);
      put(rows[i].size, rows[i].ptr, rows[i].addr, rows[i].data);
      check({8'h00, req}, 9'h001, "req");
      pull(rows[i].e_addr, rows[i].e_data, rows[i].e_size);
      check({8'h00, req}, 9'h000, "req drop");
    end
    u_wbs_partner.cfg(2'h1, 1'b0);
    for (int i = 1; i < 5; i++) begin
      check({8'h00, full}, 9'h000, "early full");
      put(2'h3, 2'h0, 8'(16 * i), 9'(i));
    end
    check({7'h00, full, d_oe}, 9'h002, "full");
    pull(8'h10, 9'h001, 2'h3);
    check({8'h00, full}, 9'h000, "full drop");
    put(2'h3, 2'h0, 8'h50, 9'h005);
    for (int i = 2; i < 6; i++) begin
      pull(8'(16 * i), 9'(i), 2'h3);
    end
    u_wbs_partner.cfg(2'h0, 1'b0);
    put(2'h0, 2'h0, 8'h80, 9'h011);
    put(2'h0, 2'h0, 8'h80, 9'h022);
    put(2'h1, 2'h2, 8'h80, 9'h044);
    put(2'h0, 2'h0, 8'h80, 9'h055);
    put(2'h0, 2'h1, 8'h90, 9'h066);
    check({8'h00, full}, 9'h000, "gathered");
    put(2'h0, 2'h3, 8'h80, 9'h077);
    check({8'h00, full}, 9'h001, "separate");
    pull(8'h80, 9'h011, 2'h0);
    pull(8'h80, 9'h055, 2'h2);
    pull(8'h91, 9'h000, 2'h0);
    pull(8'h83, 9'h000, 2'h0);
    stop_test();
  end
endmodule
